// File: logic/fcui_pkg.sv
// Notes on behaviour
// - One write of FFH anywhere selects array reads until another command arrives.
// - After 90H, reads at identifier addresses return maker, device and block codes.
// - After 98H, reads at query offsets return the query database.
// - After 70H, a read at any address returns the status byte.
// - One write of 50H clears the sticky error flags.
// - Block erase is 20H then D0H, both inside the target block.
// - Chip erase is 30H then D0H at any valid address.
// - Single write setup is 40H or 10H; the next write carries address and data.
// - Multi write is E8H, count minus one, N address/data pairs, then D0H.
// - B0H suspends an erase or write; D0H resumes it.
// - Setting a lock bit is 60H then 01H inside the block.
// - B8H then 00H to 03H chooses level or pulse modes of the ready pin.
// - The host issues only defined command codes.
// - The host never holds output enable and write enable low together.
package fcui_pkg;
  localparam int CLK_NS    = 25;
  localparam int PHASE_NS  = 100;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_DATA  = 8'h08;
  localparam logic [7:0] REG_CTRL  = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_BUF   = 8'h14;
  localparam logic [7:0] REG_RDATA = 8'h18;

  localparam int         CTRL_WP  = 0;
  localparam int         CTRL_RP  = 1;
  localparam int         CTRL_ALT = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;

  localparam int ST_BUSY    = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_SUSP    = 2;
  localparam int ST_READY   = 3;
  localparam int ST_MODE    = 4;
  localparam int ST_CNT     = 8;

  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_QUERY        = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CHIP_SETUP   = 8'h30;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;
  localparam logic [7:0] CMD_MULTI_SETUP  = 8'hE8;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET     = 8'h01;
  localparam logic [7:0] CMD_STS_SETUP    = 8'hB8;
  localparam logic [7:0] STS_MODE_MAX     = 8'h03;

  localparam logic [3:0] OP_READ_ARRAY   = 4'h0;
  localparam logic [3:0] OP_READ_ID      = 4'h1;
  localparam logic [3:0] OP_QUERY        = 4'h2;
  localparam logic [3:0] OP_READ_STATUS  = 4'h3;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h4;
  localparam logic [3:0] OP_BLOCK_ERASE  = 4'h5;
  localparam logic [3:0] OP_CHIP_ERASE   = 4'h6;
  localparam logic [3:0] OP_WORD_WRITE   = 4'h7;
  localparam logic [3:0] OP_MULTI_WRITE  = 4'h8;
  localparam logic [3:0] OP_SUSPEND      = 4'h9;
  localparam logic [3:0] OP_RESUME       = 4'hA;
  localparam logic [3:0] OP_LOCK_SET     = 4'hB;
  localparam logic [3:0] OP_LOCK_CLEAR   = 4'hC;
  localparam logic [3:0] OP_STS_CONFIG   = 4'hD;
  localparam logic [3:0] OP_BUS_READ     = 4'hE;
  localparam logic [3:0] OP_UNDEF        = 4'hF;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_QUERY, MODE_STATUS} fcui_mode_t;
  typedef enum logic [2:0] {B_IDLE, B_FETCH, B_LOAD, B_SETUP, B_STROBE, B_HOLD} fcui_bus_t;
  typedef struct packed {
    logic       rd;
    logic       mem;
    logic       last;
    logic [7:0] val;
  } fcui_step_t;
endpackage

// File: logic/fcui_mem_if.sv
`timescale 1ns/1ps
interface fcui_mem_if #(
  parameter int IW = 5,
  parameter int WW = 29
);
  logic          we;
  logic [IW-1:0] waddr;
  logic [WW-1:0] wdata;
  logic          re;
  logic [IW-1:0] raddr;
  logic [WW-1:0] rdata;
  modport ctl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// File: logic/fcui_pair_mem.sv
`timescale 1ns/1ps
module fcui_pair_mem #(
  parameter int DEPTH = 32,
  parameter int IW    = 5,
  parameter int WW    = 29
) (
  input wire logic clk,
  fcui_mem_if.mem  port_m
);
  // Storage holds no control state, so it has no reset.
  logic [WW-1:0] cell_q [DEPTH];
  logic [WW-1:0] rdata_q;

  always_ff @(posedge clk) begin
    if (port_m.we) begin
      cell_q[port_m.waddr] <= port_m.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (port_m.re) begin
      rdata_q <= cell_q[port_m.raddr];
    end
  end

  assign port_m.rdata = rdata_q;
endmodule

// File: logic/fcui_host_ctrl.sv
`timescale 1ns/1ps
module fcui_host_ctrl
  import fcui_pkg::*;
#(
  parameter int AW    = 21,
  parameter int DEPTH = 32
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  output logic      [AW-1:0] flash_addr,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  input  wire logic [7:0]    flash_dq_in,
  output logic      [7:0]    flash_dq_out,
  output logic               flash_dq_oe,
  output logic               reset_powerdown_n,
  output logic               wp_n,
  input  wire logic          ready_busy_level,
  input  wire logic          program_lockout_level
);
  localparam int SW  = $clog2(DEPTH + 3);
  localparam int IW  = $clog2(DEPTH);
  localparam int WW  = AW + 8;
  localparam int DVW = $clog2(PHASE_CYC + 1);
  localparam logic [DVW-1:0] DIV_LOAD = DVW'(PHASE_CYC - 1);

  if (AW < 1 || AW > 24 || DEPTH < 2 || DEPTH > 128) begin : g_bad
    $error("Unsupported parameter values.");
  end

  function automatic fcui_step_t step_of(input logic [3:0] op, input logic [SW-1:0] st,
                                         input logic [SW-1:0] n, input logic alt,
                                         input logic [7:0] arg);
    fcui_step_t s;
    s = '{rd: 1'b0, mem: 1'b0, last: (st == SW'(1)), val: arg};
    case (op)
      OP_READ_ARRAY: begin
        s.last = 1'b1;
        s.val  = CMD_READ_ARRAY;
      end
      OP_READ_ID: begin
        s.rd  = (st == SW'(1));
        s.val = CMD_READ_ID;
      end
      OP_QUERY: begin
        s.rd  = (st == SW'(1));
        s.val = CMD_QUERY;
      end
      OP_READ_STATUS: begin
        s.rd  = (st == SW'(1));
        s.val = CMD_READ_STATUS;
      end
      OP_CLEAR_STATUS: begin
        s.last = 1'b1;
        s.val  = CMD_CLEAR_STATUS;
      end
      OP_BLOCK_ERASE: s.val = (st == '0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
      OP_CHIP_ERASE:  s.val = (st == '0) ? CMD_CHIP_SETUP : CMD_CONFIRM;
      OP_WORD_WRITE: begin
        if (st == '0) begin
          s.val = alt ? CMD_WRITE_ALT : CMD_WRITE_SETUP;
        end
      end
      OP_MULTI_WRITE: begin
        s.last = (st == n + SW'(2));
        s.mem  = (st >= SW'(2)) && !s.last;
        s.val  = (st == '0) ? CMD_MULTI_SETUP : (st == SW'(1)) ? 8'(n - SW'(1)) : CMD_CONFIRM;
      end
      OP_SUSPEND: begin
        s.last = 1'b1;
        s.val  = CMD_SUSPEND;
      end
      OP_RESUME: begin
        s.last = 1'b1;
        s.val  = CMD_CONFIRM;
      end
      OP_LOCK_SET:   s.val = (st == '0) ? CMD_LOCK_SETUP : CMD_LOCK_SET;
      OP_LOCK_CLEAR: s.val = (st == '0) ? CMD_LOCK_SETUP : CMD_CONFIRM;
      OP_STS_CONFIG: s.val = (st == '0) ? CMD_STS_SETUP : {6'h00, arg[1:0]};
      OP_BUS_READ: begin
        s.rd   = 1'b1;
        s.last = 1'b1;
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

  fcui_bus_t     bus_q, bus_d;
  fcui_mode_t    mode_q, mode_d;
  logic [3:0]    op_q, op_d;
  logic [SW-1:0] step_q, step_d;
  logic [SW-1:0] cnt_q;
  logic [DVW-1:0] div_q;
  logic [AW-1:0] addr_q, faddr_q;
  logic [7:0]    data_q, rdata_q, dq_out_q;
  logic [2:0]    ctrl_q;
  logic          refused_q, suspended_q;
  logic          ce_n_q, oe_n_q, we_n_q, dq_oe_q;
  logic [31:0]   reg_rdata_q, stat_word, rd_mux;

  fcui_mem_if #(.IW(IW), .WW(WW)) mem_bus ();

  fcui_pair_mem #(.DEPTH(DEPTH), .IW(IW), .WW(WW)) u_mem (
    .clk    (clk),
    .port_m (mem_bus.mem)
  );

  wire        cmd_wr   = reg_wr && (reg_addr == REG_CMD);
  wire [3:0]  new_op   = reg_wdata[3:0];
  wire        busy     = (bus_q != B_IDLE);
  wire        alter_op = (new_op >= OP_BLOCK_ERASE && new_op <= OP_MULTI_WRITE)
                      || new_op == OP_LOCK_SET || new_op == OP_LOCK_CLEAR;
  // Array-read while the ready pin reads busy and nothing is suspended would be dropped by the device, so refuse it here.
  wire        refuse   = cmd_wr && (busy || new_op == OP_UNDEF
                      || !ctrl_q[CTRL_RP]
                      || (alter_op && program_lockout_level)
                      || (new_op == OP_READ_ARRAY && !ready_busy_level && !suspended_q)
                      || (new_op == OP_MULTI_WRITE && cnt_q == '0));
  wire        accept   = cmd_wr && !refuse;
  wire fcui_step_t cur = step_of(op_q, step_q, cnt_q, ctrl_q[CTRL_ALT], data_q);
  wire        tick     = (div_q == '0);
  wire        timed    = (bus_q == B_SETUP) || (bus_q == B_STROBE) || (bus_q == B_HOLD);
  wire        done     = (bus_q == B_HOLD) && tick && cur.last;
  wire        stat_clr = reg_wr && (reg_addr == REG_STAT);

  assign mem_bus.we    = reg_wr && (reg_addr == REG_BUF) && !busy && (cnt_q < SW'(DEPTH));
  assign mem_bus.waddr = cnt_q[IW-1:0];
  assign mem_bus.wdata = reg_wdata[WW-1:0];
  assign mem_bus.re    = (bus_q == B_FETCH) && cur.mem;
  assign mem_bus.raddr = IW'(step_q - SW'(2));

  always_comb begin
    bus_d  = bus_q;
    step_d = step_q;
    op_d   = op_q;
    case (bus_q)
      B_IDLE: begin
        if (accept) begin
          bus_d  = B_FETCH;
          step_d = '0;
          op_d   = new_op;
        end
      end
      B_FETCH:  bus_d = B_LOAD;
      B_LOAD:   bus_d = B_SETUP;
      B_SETUP:  bus_d = tick ? B_STROBE : B_SETUP;
      B_STROBE: bus_d = tick ? B_HOLD : B_STROBE;
      B_HOLD: begin
        if (tick) begin
          bus_d  = cur.last ? B_IDLE : B_FETCH;
          step_d = step_q + SW'(1);
        end
      end
      default: bus_d = B_IDLE;
    endcase
  end

  always_comb begin
    mode_d = mode_q;
    if (!ctrl_q[CTRL_RP]) begin
      mode_d = MODE_ARRAY;
    end else if (done) begin
      case (op_q)
        OP_READ_ARRAY: mode_d = MODE_ARRAY;
        OP_READ_ID:    mode_d = MODE_ID;
        OP_QUERY:      mode_d = MODE_QUERY;
        OP_CLEAR_STATUS, OP_BUS_READ, OP_RESUME: mode_d = mode_q;
        default:       mode_d = MODE_STATUS;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_q  <= B_IDLE;
      step_q <= '0;
      op_q   <= OP_READ_ARRAY;
      mode_q <= MODE_ARRAY;
      div_q  <= DIV_LOAD;
    end else begin
      bus_q  <= bus_d;
      step_q <= step_d;
      op_q   <= op_d;
      mode_q <= mode_d;
      div_q  <= (!timed || tick) ? DIV_LOAD : div_q - DVW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q      <= '0;
      data_q      <= 8'h00;
      ctrl_q      <= CTRL_RST;
      cnt_q       <= '0;
      refused_q   <= 1'b0;
      suspended_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_ADDR) addr_q <= reg_wdata[AW-1:0];
      if (reg_wr && reg_addr == REG_DATA) data_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == REG_CTRL) ctrl_q <= reg_wdata[2:0];
      if (mem_bus.we) cnt_q <= cnt_q + SW'(1);
      else if (done && op_q == OP_MULTI_WRITE) cnt_q <= '0;
      refused_q   <= refuse || (refused_q && !stat_clr);
      suspended_q <= ctrl_q[CTRL_RP] && ((done && op_q == OP_SUSPEND)
                  || (suspended_q && !(done && op_q == OP_RESUME)));
    end
  end

  // Write enable and output enable rise one phase before chip enable, so data is
  // always caught on the write-enable edge and the bus never sees both strobes low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      dq_oe_q  <= 1'b0;
      faddr_q  <= '0;
      dq_out_q <= 8'h00;
      rdata_q  <= 8'h00;
    end else begin
      if (bus_q == B_LOAD) begin
        ce_n_q   <= 1'b0;
        dq_oe_q  <= !cur.rd;
        faddr_q  <= cur.mem ? mem_bus.rdata[WW-1:8] : addr_q;
        dq_out_q <= cur.mem ? mem_bus.rdata[7:0] : cur.val;
      end
      if (bus_q == B_SETUP && tick) begin
        we_n_q <= cur.rd;
        oe_n_q <= !cur.rd;
      end
      if (bus_q == B_STROBE && tick) begin
        we_n_q <= 1'b1;
        oe_n_q <= 1'b1;
        if (cur.rd) rdata_q <= flash_dq_in;
      end
      if (bus_q == B_HOLD && tick) begin
        ce_n_q  <= 1'b1;
        dq_oe_q <= 1'b0;
      end
    end
  end

  always_comb begin
    stat_word                 = '0;
    stat_word[ST_BUSY]        = busy;
    stat_word[ST_REFUSED]     = refused_q;
    stat_word[ST_SUSP]        = suspended_q;
    stat_word[ST_READY]       = ready_busy_level;
    stat_word[ST_MODE +: 2]   = mode_q;
    stat_word[ST_CNT +: SW]   = cnt_q;
  end

  assign rd_mux = (reg_addr == REG_CMD)   ? {28'h0000000, op_q} :
                  (reg_addr == REG_ADDR)  ? 32'(addr_q) :
                  (reg_addr == REG_DATA)  ? {24'h000000, data_q} :
                  (reg_addr == REG_CTRL)  ? {29'h00000000, ctrl_q} :
                  (reg_addr == REG_STAT)  ? stat_word :
                  (reg_addr == REG_RDATA) ? {24'h000000, rdata_q} : 32'h00000000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) reg_rdata_q <= 32'h00000000;
    else reg_rdata_q <= reg_rd ? rd_mux : 32'h00000000;
  end

  assign reg_rdata         = reg_rdata_q;
  assign flash_addr        = faddr_q;
  assign flash_ce_n        = ce_n_q;
  assign flash_oe_n        = oe_n_q;
  assign flash_we_n        = we_n_q;
  assign flash_dq_out      = dq_out_q;
  assign flash_dq_oe       = dq_oe_q;
  assign reset_powerdown_n = ctrl_q[CTRL_RP];
  assign wp_n              = ctrl_q[CTRL_WP];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_oe_we_excl;
    !(!flash_oe_n && !flash_we_n);
  endproperty
  a_oe_we_excl: assert property (p_oe_we_excl)
    else $error("Output enable and write enable low together.");

  property p_we_rise_ce;
    $rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe;
  endproperty
  a_we_rise_ce: assert property (p_we_rise_ce)
    else $error("Write enable rose without chip enable and data held.");

  property p_refuse_undef;
    (cmd_wr && new_op == OP_UNDEF) |=> refused_q && $stable(op_q);
  endproperty
  a_refuse_undef: assert property (p_refuse_undef)
    else $error("Undefined operation was not refused.");

  property p_array_code;
    (bus_q == B_STROBE && op_q == OP_READ_ARRAY) |-> !flash_we_n && flash_dq_out == CMD_READ_ARRAY;
  endproperty
  a_array_code: assert property (p_array_code)
    else $error("Array read did not write its code.");

  property p_status_read;
    (bus_q == B_STROBE && tick && op_q == OP_READ_STATUS && step_q == SW'(1))
      |-> !flash_oe_n && !flash_dq_oe ##1 flash_oe_n;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read cycle malformed.");

  property p_erase_confirm;
    (bus_q == B_STROBE && op_q == OP_BLOCK_ERASE && step_q == SW'(1))
      |-> flash_dq_out == CMD_CONFIRM && flash_addr == addr_q;
  endproperty
  a_erase_confirm: assert property (p_erase_confirm)
    else $error("Block erase confirm wrong.");

  property p_multi_end;
    (done && op_q == OP_MULTI_WRITE)
      |-> flash_dq_out == CMD_CONFIRM && step_q == cnt_q + SW'(2) && step_q >= SW'(3);
  endproperty
  a_multi_end: assert property (p_multi_end)
    else $error("Multi write did not end with confirm after the pairs.");

  property p_lock_set;
    (bus_q == B_STROBE && op_q == OP_LOCK_SET)
      |-> flash_dq_out == ((step_q == '0) ? CMD_LOCK_SETUP : CMD_LOCK_SET);
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("Lock set sequence wrong.");

  property p_sts_cfg;
    (bus_q == B_STROBE && op_q == OP_STS_CONFIG && step_q == SW'(1)) |-> flash_dq_out <= STS_MODE_MAX;
  endproperty
  a_sts_cfg: assert property (p_sts_cfg)
    else $error("Ready pin configuration out of range.");

  property p_no_cmd_pd;
    (bus_q == B_IDLE && !ctrl_q[CTRL_RP]) |=> bus_q == B_IDLE;
  endproperty
  a_no_cmd_pd: assert property (p_no_cmd_pd)
    else $error("Command started in power-down.");

  property p_suspend;
    (done && op_q == OP_SUSPEND && ctrl_q[CTRL_RP]) |=> suspended_q && mode_q == MODE_STATUS;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("Suspend not recorded.");
endmodule

// File: verification/fcui_flash_model.sv
`timescale 1ns/1ps
module fcui_flash_model #(
  parameter int         AW      = 21,
  parameter logic [7:0] MAKER   = 8'h5A,  // Arbitrary value.
  parameter int         BUSY_NS = 5000
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic [7:0]    dq_w,
  input  wire logic          rp_n,
  input  wire logic          wp_n,
  input  wire logic          lockout,
  output logic      [7:0]    dq_r,
  output logic               rdy,
  output logic      [1:0]    sts_cfg
);
  logic [7:0] mem [16];
  logic [3:0] lock;
  logic [1:0] mode;
  logic [7:0] pend;
  logic [7:0] rd_val;
  logic       busy;
  logic       susp;
  logic       err;
  int         left;
  wire  [1:0] blk = addr[3:2];

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'hA0 + 8'(i);
    lock = 4'h0;
    mode = 2'h0;
    pend = 8'h00;
    busy = 1'b0;
    susp = 1'b0;
    err = 1'b0;
    left = 0;
    sts_cfg = 2'h0;
  end

  always_comb begin
    case (mode)
      2'h0: rd_val = mem[addr[3:0]];
      2'h1: rd_val = (addr[3:0] == 4'h0) ? MAKER : {7'h00, lock[blk]};
      2'h2: rd_val = (addr[5:0] == 6'h10) ? 8'h51 : 8'h00;
      default: rd_val = {!busy, susp, 1'b0, err, 4'h0};
    endcase
  end

  // A released bus shows the inverse, so a late sample cannot match by luck.
  assign dq_r = (!ce_n && !oe_n && rp_n) ? rd_val : ~rd_val;
  // The pin is open drain with a pull-up, so floating reads high.
  assign rdy = !(busy && !susp && sts_cfg == 2'h0) || !rp_n;

  always @(negedge rp_n) begin
    mode = 2'h0;
    pend = 8'h00;
    left = 0;
    busy = 1'b0;
    susp = 1'b0;
  end

  always @(posedge busy) begin
    #(BUSY_NS);
    wait (!susp);
    busy = 1'b0;
  end

  always @(posedge we_n or posedge ce_n) begin : take
    logic bad;
    bad = lockout || (lock[blk] && !wp_n);
    if (rp_n && (we_n ^ ce_n)) begin
      if (left > 0) begin
        if (bad) err = 1'b1;
        else mem[addr[3:0]] = dq_w;
        left = left - 1;
      end else if (pend == 8'hE8) begin
        left = int'(dq_w) + 1;
        pend = 8'hE9;
      end else if (pend != 8'h00) begin
        case (pend)
          8'h20: if (bad) err = 1'b1;
            else for (int i = 0; i < 4; i++) mem[{blk, 2'(i)}] = 8'hFF;
          8'h30: if (!lockout) for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
          8'h40, 8'h10: if (bad) err = 1'b1;
            else mem[addr[3:0]] = dq_w;
          8'h60: if (lockout) err = 1'b1;
            else if (dq_w == 8'h01) lock[blk] = 1'b1;
            else if (wp_n) lock = 4'h0;
          8'hB8: sts_cfg = dq_w[1:0];
          default: ;
        endcase
        busy = (pend != 8'hB8);
        pend = 8'h00;
      end else begin
        case (dq_w)
          8'hFF: if (!busy || susp) mode = 2'h0;
          8'h90: mode = 2'h1;
          8'h98: mode = 2'h2;
          8'h70: mode = 2'h3;
          8'h50: err = 1'b0;
          8'hB0: susp = busy;
          8'hD0: susp = 1'b0;
          default: begin
            pend = dq_w;
            mode = 2'h3;
          end
        endcase
      end
    end
  end
endmodule

// File: verification/fcui_host_ctrl_tb.sv
`timescale 1ns/1ps
module fcui_host_ctrl_tb
  import fcui_pkg::*;
;
  localparam int         AW    = 21;
  localparam logic [7:0] MAKER = 8'h5A;  // Arbitrary value.
  logic          clk;
  logic          nrst;
  logic          reg_wr;
  logic          reg_rd;
  logic          lockout;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic [31:0]   reg_rdata;
  logic [31:0]   rd_q;
  logic [AW-1:0] f_addr;
  logic          ce_n;
  logic          oe_n;
  logic          we_n;
  logic          dq_oe;
  logic          rp_n;
  logic          wp_n;
  logic          rdy;
  logic [7:0]    dq_in;
  logic [7:0]    dq_out;
  logic [1:0]    sts_cfg;
  int            n_mismatch = 0;
  int            samples_checked = 0;

  fcui_host_ctrl #(.AW(AW)) i_fcui_host_ctrl (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(f_addr),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_in(dq_in),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .reset_powerdown_n(rp_n), .wp_n(wp_n),
    .ready_busy_level(rdy), .program_lockout_level(lockout));

  fcui_flash_model #(.AW(AW), .MAKER(MAKER)) i_fcui_flash_model (
    // An undriven data bus reaches the flash inverted, so a missing drive corrupts the write.
    .addr(f_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(dq_oe ? dq_out : ~dq_out),
    .rp_n(rp_n), .wp_n(wp_n), .lockout(lockout), .dq_r(dq_in), .rdy(rdy), .sts_cfg(sts_cfg));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken at that edge.
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rd_q = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_q & m, e);
  endtask

  task automatic waitbit(input int b, input logic v);
    int k;
    k = 0;
    rd(REG_STAT);
    while (rd_q[b] !== v && k < 2000) begin
      rd(REG_STAT);
      k++;
    end
    if (rd_q[b] !== v) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  task automatic op(input logic [3:0] o);
    wr(REG_CMD, {28'h0, o});
    waitbit(ST_BUSY, 1'b0);
  endtask

  task automatic arr_chk(input logic [31:0] a, input logic [31:0] e);
    wr(REG_ADDR, a);
    op(OP_BUS_READ);
    rdchk(REG_RDATA, 32'hFF, e);
  endtask

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    lockout = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({27'h0, ce_n, oe_n, we_n, rp_n, wp_n}, 32'h1E);
    rdchk(REG_CTRL, 32'h7, 32'h2);
    rdchk(8'h1C, 32'hFFFFFFFF, 32'h0);
    wr(REG_CMD, 32'hF);
    rdchk(REG_STAT, 32'h3, 32'h2);
    rdchk(REG_CMD, 32'hF, 32'h0);
    wr(REG_STAT, 32'h0);
    rdchk(REG_STAT, 32'h30, 32'h0);
    arr_chk(32'h3, 32'hA3);
    wr(REG_CTRL, 32'h3);
    for (int i = 3; i >= 0; i--) begin
      wr(REG_DATA, 32'(i));
      op(OP_STS_CONFIG);
      chk({30'h0, sts_cfg}, 32'(i));
    end
    wr(REG_ADDR, 32'h0);
    op(OP_READ_ID);
    rdchk(REG_RDATA, 32'hFF, {24'h0, MAKER});
    wr(REG_ADDR, 32'h10);
    op(OP_QUERY);
    rdchk(REG_RDATA, 32'hFF, 32'h51);
    op(OP_READ_STATUS);
    rdchk(REG_RDATA, 32'hFF, 32'h80);
    // The second pass uses the alternate setup code.
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, 32'(3 + 4 * i));
      wr(REG_ADDR, 32'(5 + i));
      wr(REG_DATA, 32'(8'h3C + i));
      op(OP_WORD_WRITE);
      waitbit(ST_READY, 1'b1);
    end
    op(OP_READ_ARRAY);
    for (int i = 0; i < 2; i++) arr_chk(32'(5 + i), 32'(8'h3C + i));
    wr(REG_ADDR, 32'h4);
    op(OP_BLOCK_ERASE);
    rdchk(REG_STAT, 32'h8, 32'h0);
    op(OP_READ_ARRAY);
    rdchk(REG_STAT, 32'h2, 32'h2);
    wr(REG_STAT, 32'h0);
    op(OP_SUSPEND);
    op(OP_READ_ARRAY);
    rdchk(REG_STAT, 32'hE, 32'hC);
    op(OP_RESUME);
    waitbit(ST_READY, 1'b1);
    arr_chk(32'h4, 32'hFF);
    wr(REG_CTRL, 32'h3);
    wr(REG_ADDR, 32'h8);
    op(OP_LOCK_SET);
    waitbit(ST_READY, 1'b1);
    op(OP_READ_ID);
    rdchk(REG_RDATA, 32'h1, 32'h1);
    wr(REG_CTRL, 32'h2);
    op(OP_WORD_WRITE);
    waitbit(ST_READY, 1'b1);
    op(OP_READ_STATUS);
    rdchk(REG_RDATA, 32'h10, 32'h10);
    op(OP_CLEAR_STATUS);
    op(OP_READ_STATUS);
    rdchk(REG_RDATA, 32'h10, 32'h0);
    wr(REG_CTRL, 32'h3);
    op(OP_LOCK_CLEAR);
    waitbit(ST_READY, 1'b1);
    op(OP_READ_ID);
    rdchk(REG_RDATA, 32'h1, 32'h0);
    lockout <= 1'b1;
    wr(REG_STAT, 32'h0);
    op(OP_WORD_WRITE);
    rdchk(REG_STAT, 32'h2, 32'h2);
    wr(REG_STAT, 32'h0);
    op(OP_BUS_READ);
    rdchk(REG_STAT, 32'h2, 32'h0);
    lockout <= 1'b0;
    for (int i = 0; i < 2; i++) wr(REG_BUF, 32'(((12 + i) << 8) + 8'h40 + i));
    rdchk(REG_STAT, 32'hFF00, 32'h200);
    op(OP_MULTI_WRITE);
    waitbit(ST_READY, 1'b1);
    op(OP_READ_ARRAY);
    for (int i = 0; i < 2; i++) arr_chk(32'(12 + i), 32'(8'h40 + i));
    wr(REG_STAT, 32'h0);
    op(OP_MULTI_WRITE);
    rdchk(REG_STAT, 32'h2, 32'h2);
    op(OP_CHIP_ERASE);
    waitbit(ST_READY, 1'b1);
    op(OP_READ_ARRAY);
    arr_chk(32'h3, 32'hFF);
    op(OP_READ_STATUS);
    wr(REG_CTRL, 32'h1);
    chk({31'h0, rp_n}, 32'h0);
    rdchk(REG_STAT, 32'h30, 32'h0);
    wr(REG_STAT, 32'h0);
    op(OP_READ_ARRAY);
    rdchk(REG_STAT, 32'h2, 32'h2);
    wr(REG_CTRL, 32'h3);
    arr_chk(32'hD, 32'hFF);
    finish_test();
  end
endmodule
